// >>> rtl/ssfm_cfg.svh
// Purpose: Constants for the safe stop feedback monitor.
// Assumes: 40 MHz system clock.
// Notes: Times are kept in their printed unit; cycle counts derive from them.
`ifndef SSFM_CFG_SVH
`define SSFM_CFG_SVH
`define SSFM_CLK_HZ 40000000
// OFF filter window in microseconds; an OFF must outlast it.
`define SSFM_FILTER_US 500
`define SSFM_FILTER_CYC ((`SSFM_CLK_HZ / 1000000) * `SSFM_FILTER_US + 1)
// Mismatch time in seconds.
`define SSFM_MISMATCH_S 10
`define SSFM_MISMATCH_CYC (`SSFM_CLK_HZ * `SSFM_MISMATCH_S)
// Longest allowed response time in milliseconds.
`define SSFM_MAX_DELAY_MS 20
`define SSFM_MAX_DELAY_CYC ((`SSFM_CLK_HZ / 1000) * `SSFM_MAX_DELAY_MS)
`define SSFM_RESET_SYNC 2'h3
`endif

// >>> rtl/ssfm_pkg.sv
// Purpose: Types for the safe stop feedback monitor.
// Assumes: Nothing beyond the config header.
// Notes: Holds only types.
package ssfm_pkg;
  typedef enum logic [1:0] {
    SSFM_RUN = 2'h0,
    SSFM_PART = 2'h1,
    SSFM_STOP = 2'h2
  } ssfm_mode_t;
endpackage

// >>> rtl/ssfm_chan.sv
// Purpose: One stop request channel: synchroniser and OFF filter.
// Assumes: Input high means ON (normal), low means OFF (stop request).
// Notes: Filtered level only moves to OFF after a sustained OFF.
`timescale 1ns/10ps
`default_nettype none
`include "ssfm_cfg.svh"
module ssfm_chan #(
  parameter int FILT_CYC = `SSFM_FILTER_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic raw_in,
  output logic on_out
);
  import ssfm_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic on;
    logic [31:0] cnt;
  } ssfm_chan_st_t;

  ssfm_chan_st_t st, next_st;

  // ------------------------------------------------------------
  // Synchroniser and filter
  // ------------------------------------------------------------
  // The first stage feeds only the second; the filter reads the second.
  always_comb begin
    next_st = st;
    next_st.sync1 = raw_in;
    next_st.sync2 = st.sync1;
    if (st.sync2) begin
      next_st.cnt = 32'h0;
      next_st.on = 1'b1; // Return to ON is taken at once: it is the safe-to-run direction only after the unit acts.
    end else if (st.cnt >= FILT_CYC - 1) begin
      next_st.on = 1'b0;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  // Reset assumes inputs OFF so nothing runs before the inputs are seen.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign on_out = st.on;

  a_filter_short: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(st.on) |-> (!$past(st.sync2) && ($past(st.cnt) >= FILT_CYC - 1)))
    else $error("Channel went OFF without a sustained OFF level.");
endmodule
`default_nettype wire

// >>> rtl/ssfm_top.sv
// Purpose: Safe stop feedback monitor for two stop request channels.
// Assumes: Inputs synchronous to clk_in; high level means ON.
// Notes: Feedback, indication, motor enable, state monitor and alarm.
`timescale 1ns/10ps
`default_nettype none
`include "ssfm_cfg.svh"
module ssfm_top #(
  parameter int FILT_CYC = `SSFM_FILTER_CYC,
  parameter int MISMATCH_CYC = `SSFM_MISMATCH_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic stop_request_in_a,
  input wire logic stop_request_in_b,
  input wire logic alarm_clear_in,
  output logic safety_feedback_out,
  output logic cutoff_display_out,
  output logic motor_enable_out,
  output logic [1:0] safety_input_state_monitor_out,
  output logic input_timing_mismatch_alarm_out,
  output ssfm_pkg::ssfm_mode_t mode_out
);
  import ssfm_pkg::*;

  logic on_a;
  logic on_b;

  // ------------------------------------------------------------
  // Channel front ends
  // ------------------------------------------------------------
  // One instance per channel keeps both paths identical.
  ssfm_chan #(.FILT_CYC(FILT_CYC)) u_chan_a (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .raw_in(stop_request_in_a),
    .on_out(on_a)
  );

  ssfm_chan #(.FILT_CYC(FILT_CYC)) u_chan_b (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .raw_in(stop_request_in_b),
    .on_out(on_b)
  );

  typedef struct packed {
    logic feedback;
    logic display;
    logic motor_en;
    logic [1:0] monitor;
    logic alarm;
    logic [31:0] mis_cnt;
    ssfm_mode_t mode;
  } ssfm_top_st_t;

  ssfm_top_st_t st, next_st;

  // ------------------------------------------------------------
  // State evaluation
  // ------------------------------------------------------------
  // Outputs are registered one cycle after the filtered levels, far inside 20 ms.
  always_comb begin
    next_st = st;
    next_st.feedback = !on_a && !on_b;
    next_st.display = !on_a && !on_b;
    // Motor runs only with both channels ON; any OFF drops it, the safer reading.
    next_st.motor_en = on_a && on_b;
    next_st.monitor = {on_b, on_a};
    case ({on_a, on_b})
      2'h3: next_st.mode = SSFM_RUN;
      2'h0: next_st.mode = SSFM_STOP;
      default: next_st.mode = SSFM_PART;
    endcase
    if (on_a != on_b) begin
      if (st.mis_cnt >= MISMATCH_CYC - 1) begin
        next_st.alarm = 1'b1;
      end else begin
        next_st.mis_cnt = st.mis_cnt + 32'h1;
      end
    end else begin
      next_st.mis_cnt = 32'h0;
    end
    // The alarm is sticky; a clear is refused while the mismatch persists, so a set wins.
    if (alarm_clear_in && !(on_a != on_b && st.mis_cnt >= MISMATCH_CYC - 1)) begin
      next_st.alarm = 1'b0;
    end
  end

  // Reset shows the stopped condition on display, motor and mode, with feedback held low, so nothing moves before inputs settle.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st <= '{feedback: 1'b0, display: 1'b1, motor_en: 1'b0, monitor: 2'h0,
              alarm: 1'b0, mis_cnt: 32'h0, mode: SSFM_STOP};
    end else begin
      st <= next_st;
    end
  end

  assign safety_feedback_out = st.feedback;
  assign cutoff_display_out = st.display;
  assign motor_enable_out = st.motor_en;
  assign safety_input_state_monitor_out = st.monitor;
  assign input_timing_mismatch_alarm_out = st.alarm;
  assign mode_out = st.mode;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_feedback_both_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> (safety_feedback_out == $past(!on_a && !on_b)))
    else $error("Feedback does not match both-OFF state.");
  a_feedback_normal: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (on_a && on_b) |=> !safety_feedback_out)
    else $error("Feedback on during normal operation.");
  a_feedback_delay: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!on_a && !on_b) [*2] |-> safety_feedback_out)
    else $error("Feedback late after both OFF.");
  a_display_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!on_a && !on_b) |=> cutoff_display_out && !motor_enable_out)
    else $error("Stop indication or motor state wrong.");
  a_motor_cut: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(on_a && on_b) |=> !motor_enable_out)
    else $error("Motor not cut after an OFF.");
  a_monitor_state: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> safety_input_state_monitor_out == $past({on_b, on_a}))
    else $error("State monitor does not follow inputs.");
  a_alarm_match: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(input_timing_mismatch_alarm_out) |-> $past(on_a != on_b, 2))
    else $error("Alarm rose without mismatch.");
  a_sync_path: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(on_a) |-> $past(stop_request_in_a, 3))
    else $error("Channel A rose without synchronised input.");


  // ------------------------------------------------------------
  // Motor and indication cross-checks
  // ------------------------------------------------------------
  // The feedback and the motor enable must never claim opposite things at once:
  // a stop proven to the safety unit while current still flows would defeat
  // the whole point of the feedback path.
  a_fb_motor_excl: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(safety_feedback_out && motor_enable_out))
    else $error("Feedback and motor enable high together.");

  // With both channels ON the motor is released one cycle later.
  a_motor_run: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (on_a && on_b) |=> motor_enable_out)
    else $error("Motor not released with both channels ON.");

  // Any channel still ON means the stop indication must go away.
  a_display_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (on_a || on_b) |=> !cutoff_display_out)
    else $error("Stop indication shown while a channel is ON.");

  // A single OFF channel is already enough to cut the motor.
  a_single_off_cut: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (on_a != on_b) |=> !motor_enable_out)
    else $error("Motor enabled with one channel OFF.");

  // ------------------------------------------------------------
  // Feedback timing
  // ------------------------------------------------------------
  // The filtered pair reaches the pin one register later, so a change must
  // show within a single cycle; this is far inside the 20 ms window and
  // leaves the whole allowance to the filter in front.
  a_feedback_lag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $changed(!on_a && !on_b) |=> safety_feedback_out == $past(!on_a && !on_b))
    else $error("Feedback lags the filtered channels.");

  // Feedback only rises when both channels were seen OFF the cycle before.
  a_feedback_rise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(safety_feedback_out) |-> $past(!on_a && !on_b))
    else $error("Feedback rose without both channels OFF.");

  // ------------------------------------------------------------
  // Mismatch alarm behaviour
  // ------------------------------------------------------------
  // The alarm is sticky: it only falls after a clear request. A user must
  // know that removing the fault alone does not silence it.
  a_alarm_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(input_timing_mismatch_alarm_out) |-> $past(alarm_clear_in))
    else $error("Alarm fell without a clear request.");

  // A clear arriving while the mismatch still stands must be refused.
  a_alarm_clear_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (input_timing_mismatch_alarm_out && (on_a != on_b) && st.mis_cnt >= MISMATCH_CYC - 1)
    |=> input_timing_mismatch_alarm_out)
    else $error("Alarm cleared while the mismatch persisted.");

  // Matching channels never raise the alarm.
  a_alarm_no_false: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!input_timing_mismatch_alarm_out && (on_a == on_b)) |=> !input_timing_mismatch_alarm_out)
    else $error("Alarm raised with matching channels.");

  // ------------------------------------------------------------
  // Channel B synchroniser check
  // ------------------------------------------------------------
  // Channel B mirrors channel A; both must honour the two-flop path.
  a_sync_path_b: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(on_b) |-> $past(stop_request_in_b, 3))
    else $error("Channel B rose without synchronised input.");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  // These show that stop, restart, alarm and one-sided stop were all reached.
  c_stop: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(safety_feedback_out));
  c_restart: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(motor_enable_out));
  c_alarm: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(input_timing_mismatch_alarm_out));
  c_partial: cover property (@(posedge clk_in) disable iff (!reset_n_in) mode_out == SSFM_PART);
endmodule
`default_nettype wire

// >>> tb/ssfm_safety_unit.sv
// Purpose: Safety unit model that drives both stop channels and reads the feedback.
// Assumes: Channel high means ON; feedback high means both channels seen OFF.
// Notes: stuck_in keeps channel B ON, as a welded contact would.
`timescale 1ns/10ps
`default_nettype none
module ssfm_safety_unit (
  input wire logic clk_in,
  input wire logic guard_open_in,
  input wire logic stuck_in,
  input wire logic feedback_in,
  output logic chan_a_out,
  output logic chan_b_out,
  output logic armed_out
);
  // ------------------------------------------------------------
  // Guard handling and restart
  // ------------------------------------------------------------
  // Restart waits for proof that both channels went OFF, so one stuck channel blocks it.
  initial begin
    armed_out = 1'b1;
    chan_a_out = 1'b1;
    chan_b_out = 1'b1;
  end
  always @(negedge clk_in) begin
    if (guard_open_in) begin
      chan_a_out <= 1'b0;
      chan_b_out <= stuck_in;
      armed_out <= feedback_in;
    end else if (armed_out) begin
      chan_a_out <= 1'b1;
      chan_b_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_safe_stop_feedback_monitor.sv
// Purpose: Self-checking bench for the stop feedback monitor.
// Assumes: Short filter and mismatch counts set by parameter.
// Notes: A glitch mask lets the bench pulse channel A on its own.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module test_safe_stop_feedback_monitor;
  import ssfm_pkg::*;
  localparam int FILT = 5;
  localparam int WAIT = FILT + 8;
  logic clk_in, reset_n_in, guard, stuck, glitch, clr, fb, disp, mot, alarm, armed, ch_a, ch_b;
  logic [1:0] mon;
  ssfm_mode_t mode;
  int err_count, n_tests, cycles;
  ssfm_safety_unit i_ssfm_safety_unit (.clk_in(clk_in), .guard_open_in(guard), .stuck_in(stuck),
    .feedback_in(fb), .chan_a_out(ch_a), .chan_b_out(ch_b), .armed_out(armed));
  ssfm_top #(.FILT_CYC(FILT), .MISMATCH_CYC(50)) i_ssfm_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .stop_request_in_a(ch_a & ~glitch), .stop_request_in_b(ch_b), .alarm_clear_in(clr),
    .safety_feedback_out(fb), .cutoff_display_out(disp), .motor_enable_out(mot),
    .safety_input_state_monitor_out(mon), .input_timing_mismatch_alarm_out(alarm), .mode_out(mode));
  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  // The ceiling is far above the 175 cycles the scenarios need.
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Power-up: stop state in reset, then both ON gives run with feedback off.
  task automatic t_power_up();
    `CHK("disp_rst", 1'b1, disp)
    `CHK("mot_rst", 1'b0, mot)
    reset_n_in = 1'b1;
    settle(WAIT);
    `CHK("fb_run", 1'b0, fb)
    `CHK("mon_run", 2'h3, mon)
    `CHK("mot_run", 1'b1, mot)
  endtask
  // An OFF pulse shorter than the filter must leave everything as it was.
  task automatic t_short_pulse();
    glitch = 1'b1;
    settle(FILT - 1);
    glitch = 1'b0;
    settle(WAIT);
    `CHK("mon_glitch", 2'h3, mon)
    `CHK("mode_glitch", SSFM_RUN, mode)
  endtask
  // Guard opens, both channels drop, unit arms and restarts on closing.
  task automatic t_guard_cycle();
    guard = 1'b1;
    settle(WAIT);
    `CHK("fb_stop", 1'b1, fb)
    `CHK("disp_stop", 1'b1, disp)
    `CHK("mot_stop", 1'b0, mot)
    `CHK("mode_stop", SSFM_STOP, mode)
    guard = 1'b0;
    settle(WAIT);
    `CHK("fb_back", 1'b0, fb)
    `CHK("mon_back", 2'h3, mon)
  endtask
  // Channel B stuck ON: feedback stays off, alarm rises, restart refused.
  task automatic t_stuck_channel();
    stuck = 1'b1;
    guard = 1'b1;
    settle(WAIT);
    `CHK("fb_stuck", 1'b0, fb)
    `CHK("mon_stuck", 2'h2, mon)
    `CHK("mode_part", SSFM_PART, mode)
    `CHK("alarm_early", 1'b0, alarm)
    settle(60);
    clr = 1'b1;
    settle(1);
    clr = 1'b0;
    `CHK("alarm_set", 1'b1, alarm)
    guard = 1'b0;
    settle(WAIT);
    `CHK("armed_stuck", 1'b0, armed)
    stuck = 1'b0;
    guard = 1'b1;
    settle(WAIT);
    guard = 1'b0;
    settle(WAIT);
    clr = 1'b1;
    settle(1);
    clr = 1'b0;
    settle(2);
    `CHK("alarm_clr", 1'b0, alarm)
    `CHK("mode_fixed", SSFM_RUN, mode)
  endtask
  initial begin
    {reset_n_in, guard, stuck, glitch, clr} = '0;
    err_count = 0;
    n_tests = 0;
    cycles = 0;
    settle(3);
    t_power_up();
    t_short_pulse();
    t_guard_cycle();
    t_stuck_channel();
    finish_test();
  end
endmodule
`default_nettype wire
